/* src/pfc_counter_ctrl.sv */
`timescale 1ns/10ps
`include "pfc_regs.svh"
// Functional notes
// [RULE_01] Input divided by hundred before counter.
// [RULE_02] One-second gate from 1 MHz reference.
// [RULE_03] Gate runs prescaler; digits held afterward.
// [RULE_04] Counter overflow past 999999 gives carry.
// [RULE_05] Store pulse at every gate end.
// [RULE_06] Clear pulse follows the store.
// [RULE_07] Megahertz range: no loading, plain cycle.
// [RULE_08] Hertz range: toggle after clear enables loading.
// [RULE_09] Scan sync driven low after clear.
// [RULE_10] Shift latched digits two positions higher.
// [RULE_11] Sequence counter advances at digit six.
// [RULE_12] Digits two, one from prescaler.
// [RULE_13] Count eight: store, then clear.
// [RULE_14] Second clear resets toggle, prescaler, sequence.
// [RULE_15] No counting while digits shift.
module pfc_counter_ctrl #(
   parameter int GATE_TICKS = `PFC_GATE_TICKS
) (
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       sig_in,
   input  wire logic       ref_in,
   input  wire logic       range_select,
   input  wire logic [5:0] digit_strobe,
   input  wire logic [3:0] bcd_in,
   input  wire logic       ctr_carry,
   output logic            count_out,
   output logic            store_out,
   output logic            clear_out,
   output logic            load_counter,
   output logic [3:0]      load_data,
   output logic            scan_sync_n,
   output logic            gate,
   output logic            overflow
);
   pfc_pre_if pre ();
   pfc_prescaler u_pre (
      .clk (clk),
      .rst (rst),
      .p   (pre)
   );

   logic [2:0]  sig_sy;
   logic [2:0]  ref_sy;
   logic [2:0]  ds6_sy;
   logic [17:0] strobe_sy;
   logic [11:0] bcd_sy;
   logic        sig_lvl;
   logic        ref_lvl;
   logic        ds6_lvl;
   logic [5:0]  strobe_lvl;
   logic [19:0] ref_cnt;
   logic        gate_q;
   logic        ref_tick;
   logic        sig_edge;
   logic        ds6_rise;
   logic [5:0]  strobe_now;
   logic        strobe_start;
   logic [3:0]  pulse_cnt;
   logic        hz_toggle;
   logic [3:0]  seq;
   logic [3:0]  digit_hold [4];
   pfc_pkg::pfc_state_t state;

   function automatic logic agree(input logic [2:0] s, input logic cur);
      agree = (s[1] == s[2]) ? s[2] : cur;
   endfunction : agree

   // Three-stage synchronisers; change accepted once the last two agree.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sig_sy    <= 3'h0;
         ref_sy    <= 3'h0;
         ds6_sy    <= 3'h0;
         strobe_sy <= 18'h00000;
         bcd_sy    <= 12'h000;
         sig_lvl   <= 1'b0;
         ref_lvl   <= 1'b0;
         ds6_lvl   <= 1'b0;
         strobe_lvl <= 6'h00;
      end else begin
         sig_sy    <= {sig_sy[1:0], sig_in};
         ref_sy    <= {ref_sy[1:0], ref_in};
         ds6_sy    <= {ds6_sy[1:0], digit_strobe[5]};
         strobe_sy <= {strobe_sy[11:0], digit_strobe};
         bcd_sy    <= {bcd_sy[7:0], bcd_in};
         sig_lvl   <= agree(sig_sy, sig_lvl);
         ref_lvl   <= agree(ref_sy, ref_lvl);
         ds6_lvl   <= agree(ds6_sy, ds6_lvl);
         strobe_lvl <= strobe_now;
      end
   end

   assign sig_edge = agree(sig_sy, sig_lvl) & ~sig_lvl;
   assign ref_tick = agree(ref_sy, ref_lvl) & ~ref_lvl;
   assign ds6_rise = agree(ds6_sy, ds6_lvl) & ~ds6_lvl;
   // The whole strobe word is taken once its last two stages agree; the data
   // word has the same delay, so it is valid whenever the accepted strobe is.
   assign strobe_now   = (strobe_sy[17:12] == strobe_sy[11:6]) ? strobe_sy[17:12]
                                                               : strobe_lvl;
   assign strobe_start = (strobe_now != 6'h00) && (strobe_now != strobe_lvl);

   // [RULE_02] Divide reference by 10^6, then by two.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ref_cnt <= 20'h00000;
         gate_q  <= 1'b0;
      end else if (ref_tick) begin
         if (ref_cnt == 20'(GATE_TICKS - 1)) begin
            ref_cnt <= 20'h00000;
            gate_q  <= ~gate_q;
         end else begin
            ref_cnt <= ref_cnt + 20'h00001;
         end
      end
   end

   assign gate             = gate_q;
   assign pre.gate         = gate_q;
   // [RULE_15] Counting only while the sequencer is idle.
   assign pre.count_pulse  = sig_edge & (state == pfc_pkg::PFC_IDLE);
   assign count_out        = pre.carry;
   // [RULE_04] Carry past all nines.
   assign overflow         = ctr_carry;

   logic gate_fall;
   logic gate_d;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gate_d <= 1'b0;
      end else begin
         gate_d <= gate_q;
      end
   end
   assign gate_fall = gate_d & ~gate_q;

   // Sequencer for store, clear and the hertz shift.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state     <= pfc_pkg::PFC_IDLE;
         pulse_cnt <= 4'h0;
         hz_toggle <= 1'b0;
      end else begin
         unique case (state)
            pfc_pkg::PFC_IDLE: begin
               pulse_cnt <= 4'h0;
               // [RULE_05] Store at gate end.
               if (gate_fall) begin
                  state <= pfc_pkg::PFC_STORE1;
               end
            end
            pfc_pkg::PFC_STORE1, pfc_pkg::PFC_STORE2: begin
               if (pulse_cnt == 4'(`PFC_PULSE_CYC - 1)) begin
                  pulse_cnt <= 4'h0;
                  // [RULE_06] Clear follows store.
                  state <= (state == pfc_pkg::PFC_STORE1) ? pfc_pkg::PFC_CLEAR1
                                                          : pfc_pkg::PFC_CLEAR2;
               end else begin
                  pulse_cnt <= pulse_cnt + 4'h1;
               end
            end
            pfc_pkg::PFC_CLEAR1: begin
               if (pulse_cnt == 4'(`PFC_PULSE_CYC - 1)) begin
                  pulse_cnt <= 4'h0;
                  // [RULE_07] Megahertz: back to idle.
                  // [RULE_08] Hertz: toggle starts shift.
                  if (range_select) begin
                     hz_toggle <= 1'b1;
                     state     <= pfc_pkg::PFC_SHIFT;
                  end else begin
                     state <= pfc_pkg::PFC_IDLE;
                  end
               end else begin
                  pulse_cnt <= pulse_cnt + 4'h1;
               end
            end
            pfc_pkg::PFC_SHIFT: begin
               // [RULE_13] Eighth count ends shift.
               if (seq == `PFC_SEQ_END) begin
                  state <= pfc_pkg::PFC_STORE2;
               end
            end
            pfc_pkg::PFC_CLEAR2: begin
               if (pulse_cnt == 4'(`PFC_PULSE_CYC - 1)) begin
                  pulse_cnt <= 4'h0;
                  // [RULE_14] Second clear resets toggle.
                  hz_toggle <= 1'b0;
                  state     <= pfc_pkg::PFC_IDLE;
               end else begin
                  pulse_cnt <= pulse_cnt + 4'h1;
               end
            end
            default: begin
               state <= pfc_pkg::PFC_IDLE;
            end
         endcase
      end
   end

   assign store_out = (state == pfc_pkg::PFC_STORE1) || (state == pfc_pkg::PFC_STORE2);
   assign clear_out = (state == pfc_pkg::PFC_CLEAR1) || (state == pfc_pkg::PFC_CLEAR2);
   // [RULE_14] Prescaler cleared at second clear.
   assign pre.clear = (state == pfc_pkg::PFC_CLEAR2) &&
                      (pulse_cnt == 4'(`PFC_PULSE_CYC - 1));

   // [RULE_09] Scan sync low after each clear.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         scan_sync_n <= 1'b1;
      end else if (clear_out && pulse_cnt == 4'(`PFC_PULSE_CYC - 1)) begin
         scan_sync_n <= 1'b0;
      end else if (ds6_rise || state == pfc_pkg::PFC_IDLE) begin
         scan_sync_n <= 1'b1;
      end
   end

   // [RULE_11] Sequence counter steps at digit six.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         seq <= 4'h0;
      end else if (state == pfc_pkg::PFC_CLEAR2) begin
         seq <= 4'h0;
      end else if (state == pfc_pkg::PFC_SHIFT && ds6_rise && seq != `PFC_SEQ_END) begin
         seq <= seq + 4'h1;
      end
   end

   // [RULE_10] Latch digit, reload two positions up.
   // The display latch is frozen during the shift, so a digit held on an earlier
   // scan stays valid and repeated loads on later scans do no harm.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         digit_hold   <= '{default: 4'h0};
         load_counter <= 1'b0;
         load_data    <= 4'h0;
      end else begin
         load_counter <= 1'b0;
         if (state == pfc_pkg::PFC_SHIFT && hz_toggle && strobe_start) begin
            for (int i = 0; i < 4; i++) begin
               if (strobe_now[i]) begin
                  digit_hold[i] <= bcd_sy[11:8];
               end
            end
            // Load rises as the strobe ends; the chip keeps the last strobed digit, so it lands there.
            if (seq >= 4'h2 && seq < `PFC_SEQ_PRE && strobe_now[5:2] != 4'h0) begin
               load_counter <= 1'b1;
               load_data    <= strobe_now[5] ? digit_hold[3] :
                               strobe_now[4] ? digit_hold[2] :
                               strobe_now[3] ? digit_hold[1] : digit_hold[0];
            end else if (seq >= `PFC_SEQ_PRE && seq < `PFC_SEQ_END &&
                         strobe_now[1:0] != 2'b00) begin
               // [RULE_12] Prescaler tens and ones.
               load_counter <= 1'b1;
               load_data    <= strobe_now[1] ? pre.tens : pre.ones;
            end
         end
      end
   end
endmodule : pfc_counter_ctrl

/* src/pfc_regs.svh */
`ifndef PFC_REGS_SVH
`define PFC_REGS_SVH

// Prescaler modulus and per-decade wrap value.
`define PFC_PRESCALE      100
`define PFC_DEC_MAX       4'h9
// Reference is 1 MHz; a half-period of the gate toggle is 10^6 reference ticks.
`define PFC_REF_HZ        1000000
`define PFC_CLK_HZ        40000000
`define PFC_GATE_TICKS    1000000
// Sequence counter value that ends the hertz shift.
`define PFC_SEQ_END       4'h8
// Sequence value at which the shift moves from latched digits to prescaler digits.
`define PFC_SEQ_PRE       4'h5
// Width in clocks of the store and clear pulses.
`define PFC_PULSE_CYC     4

`endif

/* src/pfc_pkg.sv */
package pfc_pkg;
   typedef enum logic [2:0] {
      PFC_IDLE   = 3'b000,
      PFC_STORE1 = 3'b001,
      PFC_CLEAR1 = 3'b010,
      PFC_SHIFT  = 3'b011,
      PFC_STORE2 = 3'b100,
      PFC_CLEAR2 = 3'b101
   } pfc_state_t;
endpackage : pfc_pkg

/* src/pfc_pre_if.sv */
`timescale 1ns/10ps
interface pfc_pre_if;
   logic       gate;
   logic       count_pulse;
   logic       clear;
   logic [3:0] tens;
   logic [3:0] ones;
   logic       carry;
   modport ctrl (output gate, output count_pulse, output clear, input tens, input ones,
                 input carry);
   modport pre  (input gate, input count_pulse, input clear, output tens, output ones,
                 output carry);
endinterface : pfc_pre_if

/* src/pfc_prescaler.sv */
`timescale 1ns/10ps
`include "pfc_regs.svh"
// Two-decade prescaler; counts while the gate is high and holds its digits when low.
module pfc_prescaler (
   input  wire logic clk,
   input  wire logic rst,
   pfc_pre_if.pre    p
);
   logic [3:0] ones_q;
   logic [3:0] tens_q;
   logic       carry_q;

   assign p.ones  = ones_q;
   assign p.tens  = tens_q;
   assign p.carry = carry_q;

   // [RULE_03] Gate enables counting.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ones_q  <= 4'h0;
         tens_q  <= 4'h0;
         carry_q <= 1'b0;
      end else if (p.clear) begin
         ones_q  <= 4'h0;
         tens_q  <= 4'h0;
         carry_q <= 1'b0;
      end else begin
         carry_q <= 1'b0;
         // [RULE_01] Divide by hundred.
         if (p.gate && p.count_pulse) begin
            if (ones_q == `PFC_DEC_MAX) begin
               ones_q <= 4'h0;
               if (tens_q == `PFC_DEC_MAX) begin
                  tens_q  <= 4'h0;
                  carry_q <= 1'b1;
               end else begin
                  tens_q <= tens_q + 4'h1;
               end
            end else begin
               ones_q <= ones_q + 4'h1;
            end
         end
      end
   end
endmodule : pfc_prescaler

/* dv/pfc_counter_ctrl_assertions.sv */
`timescale 1ns/10ps
`include "pfc_regs.svh"
module pfc_chk #(
   parameter int GATE_TICKS = `PFC_GATE_TICKS
) (
   input wire logic       clk,
   input wire logic       rst,
   input wire logic       range_select,
   input wire logic       ctr_carry,
   input wire logic       count_out,
   input wire logic       store_out,
   input wire logic       clear_out,
   input wire logic       load_counter,
   input wire logic       scan_sync_n,
   input wire logic       gate,
   input wire logic       overflow
);
   int unsigned gcnt;
   logic        seen;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // The first gate edge after reset has no full period before it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         gcnt <= 0;
         seen <= 1'b0;
      end else if ($changed(gate)) begin
         gcnt <= 0;
         seen <= 1'b1;
      end else begin
         gcnt <= gcnt + 1;
      end
   end
   a_gate_period: assert property ($changed(gate) && seen |->
      gcnt inside {[GATE_TICKS*40-2:GATE_TICKS*40]}) else $error("gate period wrong");
   a_store_at_end: assert property ($fell(gate) |-> ##2 store_out)
      else $error("no store after gate");
   a_store_clear: assert property ($rose(store_out) |-> store_out[*4]
      ##1 (clear_out && !store_out)[*4] ##1 !clear_out) else $error("store/clear order");
   a_sync_low: assert property ($fell(clear_out) |-> ##[0:1] !scan_sync_n)
      else $error("scan sync not low");
   a_mhz_noload: assert property (!range_select |-> !load_counter)
      else $error("load in MHz range");
   a_load_idle: assert property (load_counter |-> !gate)
      else $error("load during gate");
   a_no_count: assert property (!gate[*8] |-> !count_out)
      else $error("count while gate low");
   a_carry_pass: assert property (overflow == ctr_carry)
      else $error("overflow differs");
   cover property ($rose(load_counter));
   cover property ($fell(clear_out) && range_select);
   cover property ($fell(gate));
endmodule : pfc_chk
bind pfc_counter_ctrl pfc_chk #(.GATE_TICKS(GATE_TICKS)) i_chk (.clk(clk), .rst(rst),
   .range_select(range_select), .ctr_carry(ctr_carry), .count_out(count_out),
   .store_out(store_out), .clear_out(clear_out), .load_counter(load_counter),
   .scan_sync_n(scan_sync_n), .gate(gate), .overflow(overflow));

/* dv/pfc_chip_model.sv */
`timescale 1ns/10ps
module pfc_chip_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        count,
   input  wire logic        store,
   input  wire logic        clear,
   input  wire logic        load,
   input  wire logic [3:0]  load_data,
   input  wire logic        sync_n,
   output logic      [5:0]  strobe,
   output logic      [3:0]  bcd,
   output logic             carry,
   output logic      [23:0] shown,
   output logic      [23:0] value
);
   logic [3:0] cnt [6];
   logic [3:0] disp [6];
   logic [5:0] sc;
   logic       sync_q;
   logic [2:0] k;
   logic [2:0] lk;
   assign k = 3'(5 - sc / 6);
   assign strobe = (sc % 6 inside {[1:4]}) ? 6'(1 << k) : 6'h00;
   // Between strobes the lines show the inverse, so a stale value cannot pass.
   assign bcd = (strobe != 6'h00) ? disp[k] : ~disp[k];
   always_comb begin
      for (int i = 0; i < 6; i++) begin
         shown[i*4+:4] = disp[i];
         value[i*4+:4] = cnt[i];
      end
   end
   always_ff @(posedge clk or posedge rst) begin : seq
      logic c;
      if (rst) begin
         sc <= 6'h00;
         sync_q <= 1'b1;
         lk <= 3'h0;
         carry <= 1'b0;
         cnt <= '{default: 4'h0};
         disp <= '{default: 4'h0};
      end else begin
         sync_q <= sync_n;
         sc <= ((!sync_n && sync_q) || sc == 6'd35) ? 6'h00 : sc + 6'h01;
         if (strobe != 6'h00) lk <= k;
         c = count && !clear && !load;
         for (int i = 0; i < 6; i++) begin
            if (clear) cnt[i] <= 4'h0;
            else if (load && lk == 3'(i)) cnt[i] <= load_data;
            else if (c && cnt[i] == 4'h9) cnt[i] <= 4'h0;
            else if (c) begin
               cnt[i] <= cnt[i] + 4'h1;
               c = 1'b0;
            end
         end
         carry <= c;
         if (store) disp <= cnt;
      end
   end
endmodule : pfc_chip_model

/* dv/test_pfc_counter_ctrl.sv */
`timescale 1ns/10ps
module test_pfc_counter_ctrl;
   logic        clk = 0, rst = 1, sig_in = 0, ref_in = 0, range_select = 0;
   logic [5:0]  digit_strobe;
   logic [3:0]  bcd_in, load_data;
   logic        ctr_carry, count_out, store_out, clear_out, load_counter, scan_sync_n;
   logic        gate, overflow;
   logic [23:0] shown, value;
   int          err_count = 0;
   int          num_checks = 0;
   always #12.5 clk = ~clk;
   always begin
      repeat (20) @(posedge clk);
      ref_in <= ~ref_in;
   end
   // Twenty reference ticks leave room for input edges two clocks wide each way.
   pfc_counter_ctrl #(.GATE_TICKS(20)) i_dut (.clk(clk), .rst(rst), .sig_in(sig_in),
      .ref_in(ref_in), .range_select(range_select), .digit_strobe(digit_strobe),
      .bcd_in(bcd_in), .ctr_carry(ctr_carry), .count_out(count_out), .store_out(store_out),
      .clear_out(clear_out), .load_counter(load_counter), .load_data(load_data),
      .scan_sync_n(scan_sync_n), .gate(gate), .overflow(overflow));
   pfc_chip_model i_chip (.clk(clk), .rst(rst), .count(count_out), .store(store_out),
      .clear(clear_out), .load(load_counter), .load_data(load_data), .sync_n(scan_sync_n),
      .strobe(digit_strobe), .bcd(bcd_in), .carry(ctr_carry), .shown(shown), .value(value));
   task check(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task wait_store();
      int i;
      i = 0;
      while (store_out !== 1'b1 && i < 2000) begin
         @(posedge clk);
         i++;
      end
      if (i == 2000) err_count++;
      repeat (10) @(posedge clk);
   endtask : wait_store
   // Edges start after the gate opens and stop well before it closes.
   // Each level stands two clocks, as the input filter needs two agreeing stages.
   task pulses(input int n);
      while (gate !== 1'b0) @(posedge clk);
      while (gate !== 1'b1) @(posedge clk);
      repeat (8) @(posedge clk);
      repeat (n) begin
         sig_in <= 1'b1;
         repeat (2) @(posedge clk);
         sig_in <= 1'b0;
         repeat (2) @(posedge clk);
      end
   endtask : pulses
   task test_mhz();
      range_select <= 1'b0;
      pulses(100);
      wait_store();
      check(shown, 24'h000001);
      check(value, 24'h000000);
      $display("test_mhz done");
   endtask : test_mhz
   task test_hz();
      range_select <= 1'b1;
      pulses(137);
      wait_store();
      check(shown, 24'h000001);
      wait_store();
      check(shown, 24'h000137);
      check(value, 24'h000000);
      check({23'h0, gate}, 24'h000000);
      $display("test_hz done");
   endtask : test_hz
   task stop_test();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      test_mhz();
      test_hz();
      stop_test();
   end
   initial begin
      #150us;
      err_count++;
      stop_test();
   end
endmodule : test_pfc_counter_ctrl
